// ==== rtl/period_timer_pkg.sv ====
// Constants, register map and field layout of the 8-bit period timer.
// Assumes an APB master with 32-bit data; each register is one aligned word.
// What this block does
// - Timer ticks come only from the instruction clock, pclk divided by four.
// - Count register advances by one per prescaled tick, upward from zero.
// - Prescaler divides by 1, 4, 16 or 64, chosen by control bits 1-0.
// - Count compared with period every tick; equality emits a match pulse.
// - On the matching tick the count reloads zero instead of incrementing.
// - Match pulses drive a postscaler, ratio 1:1 to 1:16 from control bits 6-3.
// - Postscaler events set sticky match flag; interrupt only while enable set.
// - Reset clears count to zero and sets period to all ones.
// - Count or control writes and reset clear both scalers; control write keeps count.
// - Software reads and writes count and period directly at any time.
// - During sleep the timer does not count; count and period hold.
// - Unscaled match pulse is output as the PWM time base.
// - Match output is selectable as the serial port shift clock source.
package period_timer_pkg;
	localparam logic [11:0] count_value_offset        = 12'h000;
	localparam logic [11:0] period_value_offset       = 12'h004;
	localparam logic [11:0] timer_control_offset      = 12'h008;
	localparam logic [11:0] peripheral_flag_offset    = 12'h00C;
	localparam logic [11:0] peripheral_enable_offset  = 12'h010;
	localparam logic [11:0] serial_clock_sel_offset   = 12'h014;
	localparam logic [7:0]  count_reset               = 8'h00;
	localparam logic [7:0]  period_reset              = 8'hFF;
	localparam logic [7:0]  control_reset             = 8'h00;
	localparam logic [6:0]  control_write_mask        = 7'h7F;
	localparam int          prescale_lsb              = 0;
	localparam int          count_enable_bit          = 2;
	localparam int          postscale_lsb             = 3;
	localparam int          match_flag_bit            = 1;
	localparam logic [1:0]  instr_div_last            = 2'h3;
	localparam logic [5:0]  prescale_last_div1        = 6'h00;
	localparam logic [5:0]  prescale_last_div4        = 6'h03;
	localparam logic [5:0]  prescale_last_div16       = 6'h0F;
	localparam logic [5:0]  prescale_last_div64       = 6'h3F;

	typedef struct packed {
		logic [3:0] postscale_select;
		logic       count_enable;
		logic [1:0] prescale_select;
	} timer_control_type;
endpackage

// ==== rtl/period_timer_8bit.sv ====
// The 8-bit period timer with prescaler, postscaler, APB registers and interrupt.
// Assumes an APB master on pclk and a sleep level synchronous to pclk.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module period_timer_8bit (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep_mode,
	output logic             match_pulse,
	output logic             pwm_time_base,
	output logic             serial_shift_clock,
	output logic             irq
);
	logic                               access;
	logic                               wr;
	logic                               wr_count;
	logic                               wr_control;
	logic                               mapped;
	logic [7:0]                         count_value;
	logic [7:0]                         period_value;
	period_timer_pkg::timer_control_type timer_control;
	logic                               match_flag;
	logic                               match_irq_enable;
	logic                               serial_clock_sel;
	logic [1:0]                         instr_div;
	logic [5:0]                         prescale_count;
	logic [5:0]                         prescale_last;
	logic [3:0]                         postscale_count;
	logic                               instr_tick;
	logic                               tick;
	logic                               match;
	logic                               post_event;
	logic [31:0]                        next_prdata;

	// Decode; every access completes in its first access cycle
	assign access     = psel && penable;
	assign wr         = access && pwrite && pstrb[0];
	assign wr_count   = wr && (paddr == period_timer_pkg::count_value_offset);
	assign wr_control = wr && (paddr == period_timer_pkg::timer_control_offset);
	assign mapped     = (paddr == period_timer_pkg::count_value_offset) ||
	                    (paddr == period_timer_pkg::period_value_offset) ||
	                    (paddr == period_timer_pkg::timer_control_offset) ||
	                    (paddr == period_timer_pkg::peripheral_flag_offset) ||
	                    (paddr == period_timer_pkg::peripheral_enable_offset) ||
	                    (paddr == period_timer_pkg::serial_clock_sel_offset);

	// Prescale terminal count per select code
	always_comb begin
		case (timer_control.prescale_select)
			2'h0:    prescale_last = period_timer_pkg::prescale_last_div1;
			2'h1:    prescale_last = period_timer_pkg::prescale_last_div4;
			2'h2:    prescale_last = period_timer_pkg::prescale_last_div16;
			2'h3:    prescale_last = period_timer_pkg::prescale_last_div64;
			default: prescale_last = period_timer_pkg::prescale_last_div1;
		endcase
	end

	// Ticks only while enabled and awake; sleep freezes the divider and every tick
	assign instr_tick = (instr_div == period_timer_pkg::instr_div_last) &&
	                    timer_control.count_enable && !sleep_mode;
	assign tick       = instr_tick && (prescale_count == prescale_last);
	assign match      = tick && (count_value == period_value);
	assign post_event = match && (postscale_count == timer_control.postscale_select);

	// Instruction clock divider, free running except in sleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_div <= 2'h0;
		end else if (!sleep_mode) begin
			instr_div <= instr_div + 2'h1;
		end
	end

	// Prescaler; cleared by count or control writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_count <= 6'h00;
		end else if (wr_count || wr_control) begin
			prescale_count <= 6'h00;
		end else if (instr_tick) begin
			prescale_count <= (prescale_count == prescale_last) ? 6'h00 :
			                  prescale_count + 6'h01;
		end
	end

	// Postscaler counts match pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			postscale_count <= 4'h0;
		end else if (wr_count || wr_control) begin
			postscale_count <= 4'h0;
		end else if (match) begin
			postscale_count <= post_event ? 4'h0 : postscale_count + 4'h1;
		end
	end

	// Count register; software write wins over a tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value <= period_timer_pkg::count_reset;
		end else if (wr_count) begin
			count_value <= pwdata[7:0];
		end else if (match) begin
			count_value <= 8'h00;
		end else if (tick) begin
			count_value <= count_value + 8'h01;
		end
	end

	// Period register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_value <= period_timer_pkg::period_reset;
		end else if (wr && (paddr == period_timer_pkg::period_value_offset)) begin
			period_value <= pwdata[7:0];
		end
	end

	// Control, enable and serial clock select registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control    <= period_timer_pkg::control_reset[6:0];
			match_irq_enable <= 1'b0;
			serial_clock_sel <= 1'b0;
		end else begin
			if (wr_control) begin
				timer_control <= pwdata[6:0] & period_timer_pkg::control_write_mask;
			end
			if (wr && (paddr == period_timer_pkg::peripheral_enable_offset)) begin
				match_irq_enable <= pwdata[period_timer_pkg::match_flag_bit];
			end
			if (wr && (paddr == period_timer_pkg::serial_clock_sel_offset)) begin
				serial_clock_sel <= pwdata[0];
			end
		end
	end

	// Sticky flag, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_flag <= 1'b0;
		end else if (post_event) begin
			match_flag <= 1'b1;
		end else if (wr && (paddr == period_timer_pkg::peripheral_flag_offset) &&
		             pwdata[period_timer_pkg::match_flag_bit]) begin
			match_flag <= 1'b0;
		end
	end

	// Read mux; unused bits read zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			period_timer_pkg::count_value_offset:      next_prdata[7:0] = count_value;
			period_timer_pkg::period_value_offset:     next_prdata[7:0] = period_value;
			period_timer_pkg::timer_control_offset:    next_prdata[6:0] = timer_control;
			period_timer_pkg::peripheral_flag_offset:
				next_prdata[period_timer_pkg::match_flag_bit] = match_flag;
			period_timer_pkg::peripheral_enable_offset:
				next_prdata[period_timer_pkg::match_flag_bit] = match_irq_enable;
			period_timer_pkg::serial_clock_sel_offset: next_prdata[0] = serial_clock_sel;
			default:                                   next_prdata = 32'h0000_0000;
		endcase
	end

	// APB answer registered: pready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

	// Registered outputs, one pclk after the match; irq level follows flag and enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_pulse        <= 1'b0;
			pwm_time_base      <= 1'b0;
			serial_shift_clock <= 1'b0;
			irq                <= 1'b0;
		end else begin
			match_pulse        <= match;
			pwm_time_base      <= match;
			serial_shift_clock <= match && serial_clock_sel;
			irq                <= (match_flag || post_event) && match_irq_enable;
		end
	end
endmodule
`default_nettype wire

// ==== verification/period_timer_8bit_sva.sv ====
// Port checker for the 8-bit period timer.
// Assumes it is bound to period_timer_8bit and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module period_timer_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sleep_mode,
	input wire logic        match_pulse,
	input wire logic        pwm_time_base,
	input wire logic        serial_shift_clock
);
	// One clock domain, so clocking and reset are given once
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_base_equal: assert property (pwm_time_base == match_pulse)
		else $error("time base differs from match");
	a_shift_gated: assert property (serial_shift_clock |-> match_pulse)
		else $error("shift clock without match");
	a_match_spacing: assert property (match_pulse |=> !match_pulse [*3])
		else $error("matches closer than four clocks");
	a_sleep_frozen: assert property (sleep_mode && $past(sleep_mode) |-> !match_pulse)
		else $error("match during sleep");
	a_ready_wait: assert property ($rose(penable) && psel |-> pready)
		else $error("ready not in first access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_unmapped_err: assert property (pready && paddr > 12'h014 |-> pslverr)
		else $error("unmapped access not refused");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside ready cycle");
	a_ctrl_top_zero: assert property (pready && !pwrite &&
		paddr == period_timer_pkg::timer_control_offset |-> prdata[31:7] == 25'h0)
		else $error("control upper bits not zero");
endmodule
bind period_timer_8bit period_timer_sva period_timer_sva_inst (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .sleep_mode, .match_pulse,
	.pwm_time_base, .serial_shift_clock);
`default_nettype wire

// ==== verification/period_timer_8bit_tb_top.sv ====
// Self-checking bench for the 8-bit period timer.
// Assumes the APB slave answers with no wait state.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module period_timer_8bit_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, sleep_mode, er;
	logic        pready, pslverr, match_pulse, pwm_time_base, serial_shift_clock, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, r0;
	logic [3:0]  pstrb;
	int          n_errors, n_checks, g, k;
	period_timer_8bit period_timer_8bit_inst (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_mode, .match_pulse,
		.pwm_time_base, .serial_shift_clock, .irq);
	// 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task complete_run;
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Ready and the answer are taken at the rising edge that ends the access
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin @(posedge pclk); if (pready === 1'b1) break; end
		if (i == 20) begin n_errors++; complete_run; end
		rd = prdata; er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// Clocks from one match pulse to the next, bounded
	task gap(output int n);
		int i;
		for (i = 0; i < 3000; i++) begin @(negedge pclk); if (match_pulse === 1'b1) break; end
		if (i >= 3000) begin n_errors++; complete_run; end
		for (n = 1; n < 3000; n++) begin @(negedge pclk); if (match_pulse === 1'b1) break; end
		if (n >= 3000) begin n_errors++; complete_run; end
	endtask
	task t_reset_and_access;
		apb(0, 12'h000, 0); `CHK("count", 32'h00, rd)
		apb(0, 12'h004, 0); `CHK("period", 32'hFF, rd)
		apb(0, 12'h018, 0); `CHK("unmapped err", 1'b1, er)
		apb(1, 12'h004, 32'h5A); apb(0, 12'h004, 0); `CHK("period rw", 32'h5A, rd)
		apb(1, 12'h008, 32'hFB); apb(0, 12'h008, 0); `CHK("control", 32'h7B, rd)
		apb(1, 12'h000, 32'h33); apb(0, 12'h000, 0); `CHK("count rw", 32'h33, rd)
		apb(0, 12'h000, 0); `CHK("count stopped", 32'h33, rd)
	endtask
	// Period 2 gives three ticks per match, each tick four clocks times the ratio
	task t_prescale;
		apb(1, 12'h014, 32'h1);
		apb(1, 12'h004, 32'h2);
		for (k = 0; k < 4; k++) begin
			apb(1, 12'h008, 32'h4 | k);
			gap(g); `CHK("match gap", 12 << (2 * k), g)
			`CHK("time base", 1'b1, pwm_time_base)
			`CHK("shift clock", 1'b1, serial_shift_clock)
		end
	endtask
	task t_postscale_irq;
		apb(1, 12'h008, 0); apb(1, 12'h00C, 32'h2); apb(1, 12'h010, 32'h2);
		apb(1, 12'h004, 0); apb(1, 12'h008, 32'h1C);
		g = 0;
		for (k = 0; k < 200; k++) begin
			@(negedge pclk);
			if (match_pulse === 1'b1) g++;
			if (irq === 1'b1) break;
		end
		`CHK("matches per flag", 4, g)
		apb(1, 12'h008, 0); apb(1, 12'h010, 0); repeat (2) @(negedge pclk);
		`CHK("masked irq", 1'b0, irq)
		apb(0, 12'h00C, 0); `CHK("sticky flag", 32'h2, rd)
		apb(1, 12'h010, 32'h2); repeat (2) @(negedge pclk); `CHK("irq on", 1'b1, irq)
		apb(1, 12'h00C, 32'h2); repeat (2) @(negedge pclk); `CHK("irq off", 1'b0, irq)
	endtask
	task t_sleep;
		apb(1, 12'h004, 32'hFF); apb(1, 12'h008, 32'h4);
		sleep_mode <= 1'b1;
		apb(0, 12'h000, 0); r0 = rd;
		repeat (40) @(posedge pclk);
		apb(0, 12'h000, 0); `CHK("sleep hold", r0, rd)
		sleep_mode <= 1'b0;
	endtask
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
		pwdata = 32'h0; pstrb = 4'hF; sleep_mode = 1'b0; n_errors = 0; n_checks = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_and_access;
		t_prescale;
		t_postscale_irq;
		t_sleep;
		complete_run;
	end
endmodule
`default_nettype wire
